/* File: rtl/mtrb_top.sv */
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module mtrb_top #(
    parameter int FAST_CYCLES = mtrb_pkg::FAST_CYCLES,
    parameter int MID_CYCLES  = mtrb_pkg::MID_CYCLES,
    parameter int SEC_CYCLES  = mtrb_pkg::SEC_CYCLES
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output var  logic [31:0] HRDATA,
    output var  logic        HREADYOUT,
    output var  logic        HRESP,
    input  wire logic        CARRIER_DET,
    input  wire logic        RING_PULSE,
    input  wire logic        OFF_HOOK,
    input  wire logic        ANSWER_MODE,
    input  wire logic        CALL_START,
    input  wire logic [7:0]  LINE_VOLTAGE,
    input  wire logic [7:0]  DSP_STATUS,
    output var  logic        CARRIER_OK,
    output var  logic        CALL_ABORT,
    output var  logic        ANSWER_TONE,
    output var  logic        RING_VALID,
    output var  logic [15:0] DSP_ADDR,
    output var  logic [13:0] DSP_DATA,
    output var  logic        DSP_DATA_WR,
    output var  logic [7:0]  DSP_CTRL_A,
    output var  logic [7:0]  DSP_CTRL_B,
    output var  logic        IRQ
);

    typedef enum logic {CALL_IDLE, CALL_WAIT} mtrb_call_t;

    // Pin synchronisers; the third stage only feeds edge detection
    logic [20:0] sync_a;
    logic [20:0] sync_b;
    logic [20:0] sync_d;
    wire  logic [20:0] pins_in = {CARRIER_DET, RING_PULSE, OFF_HOOK, ANSWER_MODE, CALL_START,
                                  LINE_VOLTAGE, DSP_STATUS};
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sync_a <= 21'h0;
            sync_b <= 21'h0;
            sync_d <= 21'h0;
        end else begin
            sync_a <= pins_in;
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    // Synchronised views; the two byte buses are assumed to move slowly
    wire logic       carrier_s = sync_b[20];
    wire logic       ring_rise = sync_b[19] & ~sync_d[19];
    wire logic       offhook_s = sync_b[18];
    wire logic       answer_s  = sync_b[17];
    wire logic       call_rise = sync_b[16] & ~sync_d[16];
    wire logic [7:0] volt_s    = sync_b[15:8];
    wire logic [7:0] dstat_s   = sync_b[7:0];

    // Free-running timebases; a wait may start anywhere within a unit
    logic [26:0] pre_fast;
    logic [26:0] pre_mid;
    logic [26:0] pre_sec;
    mtrb_pkg::mtrb_ticks_t ticks;
    wire logic wrap_fast = pre_fast == 27'(FAST_CYCLES - 1);
    wire logic wrap_mid  = pre_mid == 27'(MID_CYCLES - 1);
    wire logic wrap_sec  = pre_sec == 27'(SEC_CYCLES - 1);
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pre_fast <= 27'h0;
            pre_mid  <= 27'h0;
            pre_sec  <= 27'h0;
            ticks    <= '0;
        end else begin
            pre_fast <= wrap_fast ? 27'h0 : pre_fast + 27'h1;
            pre_mid  <= wrap_mid ? 27'h0 : pre_mid + 27'h1;
            pre_sec  <= wrap_sec ? 27'h0 : pre_sec + 27'h1;
            ticks    <= '{fast: wrap_fast, mid: wrap_mid, sec: wrap_sec};
        end
    end

    // Register storage and bus decode
    logic [7:0]  regs [0:mtrb_pkg::NSLOT-1];
    mtrb_pkg::mtrb_aphase_t dp;
    logic [mtrb_pkg::NEV-1:0] status;
    logic [7:0]  volt_rd;
    wire logic       addr_ok  = (HADDR[31:10] == 22'h0) && (HADDR[1:0] == 2'b00);
    wire logic       bus_take = HSEL & HTRANS[1] & HREADY;
    wire logic [7:0] a_idx    = HADDR[9:2];
    wire logic [3:0] a_slot   = mtrb_pkg::reg_slot(a_idx);
    wire logic       wr_dp    = dp.valid & dp.write;
    wire logic [3:0] w_slot   = mtrb_pkg::reg_slot(dp.idx);
    wire logic [7:0] wdat     = HWDATA[7:0];
    wire logic [7:0] cret_val  = regs[mtrb_pkg::SLOT_CRET];
    wire logic [7:0] cwait_val = regs[mtrb_pkg::SLOT_CWAIT];
    wire logic [7:0] tdel_val  = regs[mtrb_pkg::SLOT_TDEL];
    wire logic [7:0] pulse_min = regs[mtrb_pkg::SLOT_RPC];
    wire logic [7:0] win_mode = regs[mtrb_pkg::SLOT_WIN];
    wire logic [7:0] mask_val = regs[mtrb_pkg::SLOT_MASK];

    // Forward a write still in its data phase to a read in its address phase
    wire logic       fwd      = wr_dp && (dp.idx == a_idx);
    wire logic [7:0] slot_rd  = fwd ? wdat : regs[a_slot];
    wire logic [7:0] mode_now = (wr_dp && dp.idx == mtrb_pkg::IDX_WINDOW_SELECT) ? wdat : win_mode;
    wire logic       rd_stat  = bus_take & ~HWRITE & addr_ok & (a_idx == mtrb_pkg::IDX_IRQ_STATUS);
    wire logic [7:0] rd_val   =
        !addr_ok ? 8'h00 :
        (a_slot != mtrb_pkg::SLOT_NONE) ? slot_rd :
        (a_idx == mtrb_pkg::IDX_LINE_VOLTAGE) ? volt_rd :
        (a_idx == mtrb_pkg::IDX_WINDOW_LOW && mode_now == mtrb_pkg::WIN_STATUS) ? dstat_s :
        (a_idx == mtrb_pkg::IDX_IRQ_STATUS) ? {4'h0, status} : 8'h00;

    // Bus slave: zero wait states, read data registered from the address phase
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            dp        <= '0;
            HRDATA    <= 32'h0;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            dp        <= '{valid: bus_take & addr_ok, write: HWRITE, idx: a_idx};
            HRDATA    <= (bus_take & ~HWRITE) ? {24'h0, rd_val} : HRDATA;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // Read/write storage keeps its value until written or reset
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < mtrb_pkg::NSLOT; i++) begin
                regs[i] <= mtrb_pkg::slot_reset(4'(i));
            end
        end else if (wr_dp && w_slot != mtrb_pkg::SLOT_NONE) begin
            regs[w_slot] <= wdat;
        end
    end

    // Window writes, routed by the mode in force
    wire logic w_low  = wr_dp && dp.idx == mtrb_pkg::IDX_WINDOW_LOW;
    wire logic w_high = wr_dp && dp.idx == mtrb_pkg::IDX_WINDOW_HIGH;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            DSP_ADDR    <= 16'h0;
            DSP_DATA    <= 14'h0;
            DSP_DATA_WR <= 1'b0;
            DSP_CTRL_A  <= 8'h00;
            DSP_CTRL_B  <= 8'h00;
        end else begin
            DSP_DATA_WR <= w_high && win_mode == mtrb_pkg::WIN_DATA;
            if (w_low && win_mode == mtrb_pkg::WIN_ADDR) DSP_ADDR[7:0] <= wdat;
            if (w_high && win_mode == mtrb_pkg::WIN_ADDR) DSP_ADDR[15:8] <= wdat;
            if (w_low && win_mode == mtrb_pkg::WIN_DATA) DSP_DATA[7:0] <= wdat;
            if (w_high && win_mode == mtrb_pkg::WIN_DATA) DSP_DATA[13:8] <= wdat[5:0];
            if (w_low && win_mode == mtrb_pkg::WIN_STATUS) DSP_CTRL_A <= wdat;
            if (w_high && win_mode == mtrb_pkg::WIN_STATUS) DSP_CTRL_B <= wdat;
        end
    end

    // Carrier return qualification; one extra unit covers the timebase phase
    logic [8:0] cr_cnt;
    logic       carrier_ok;
    wire  logic cr_done = carrier_s & ~carrier_ok & mtrb_pkg::expired(cr_cnt, cret_val);
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cr_cnt     <= 9'h0;
            carrier_ok <= 1'b0;
        end else if (!carrier_s) begin
            cr_cnt     <= 9'h0;
            carrier_ok <= 1'b0;
        end else if (!carrier_ok) begin
            if (ticks.fast) cr_cnt <= mtrb_pkg::inc9(cr_cnt);
            if (cr_done) carrier_ok <= 1'b1;
        end
    end

    // Carrier wait after a call starts
    mtrb_call_t call_state;
    logic [8:0] cw_cnt;
    logic       abort_now;
    always_comb begin
        abort_now = 1'b0;
        if (call_state == CALL_WAIT && !carrier_ok) begin
            abort_now = mtrb_pkg::expired(cw_cnt, cwait_val);
        end
    end
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            call_state <= CALL_IDLE;
            cw_cnt     <= 9'h0;
            CALL_ABORT <= 1'b0;
        end else begin
            CALL_ABORT <= abort_now;
            case (call_state)
                CALL_IDLE: begin
                    cw_cnt <= 9'h0;
                    if (call_rise) call_state <= CALL_WAIT;
                end
                CALL_WAIT: begin
                    if (carrier_ok || abort_now) call_state <= CALL_IDLE;
                    else if (ticks.sec) cw_cnt <= mtrb_pkg::inc9(cw_cnt);
                end
                default: call_state <= CALL_IDLE;
            endcase
        end
    end

    // Answer tone delay after going off-hook in answer mode
    logic [8:0] at_cnt;
    logic       tone;
    wire  logic tone_arm  = offhook_s & answer_s;
    wire  logic tone_done = tone_arm & ~tone & mtrb_pkg::expired(at_cnt, tdel_val);
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            at_cnt <= 9'h0;
            tone   <= 1'b0;
        end else if (!tone_arm) begin
            at_cnt <= 9'h0;
            tone   <= 1'b0;
        end else if (!tone) begin
            if (ticks.mid) at_cnt <= mtrb_pkg::inc9(at_cnt);
            if (tone_done) tone <= 1'b1;
        end
    end

    // Ring burst: pulses counted until a silent gap ends the burst
    logic [7:0] pulse_cnt;
    logic [8:0] gap_cnt;
    logic       ring_done;
    wire  logic ring_hit = ring_rise & ~ring_done &
                           ({1'b0, pulse_cnt} + 9'h001 >= {1'b0, pulse_min});
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pulse_cnt  <= 8'h00;
            gap_cnt    <= 9'h0;
            ring_done  <= 1'b0;
            RING_VALID <= 1'b0;
        end else begin
            RING_VALID <= ring_hit;
            if (ring_rise) begin
                pulse_cnt <= (pulse_cnt == 8'hff) ? pulse_cnt : pulse_cnt + 8'h01;
                gap_cnt <= 9'h0;
                if (ring_hit) ring_done <= 1'b1;
            end else if (ticks.mid) begin
                gap_cnt <= mtrb_pkg::inc9(gap_cnt);
                if (mtrb_pkg::expired(gap_cnt, mtrb_pkg::RING_GAP_UNITS)) begin
                    pulse_cnt <= 8'h00;
                    ring_done <= 1'b0;
                end
            end
        end
    end

    // Line voltage status, squelched near zero
    wire logic volt_small = ($signed(volt_s) > -8'sd3) && ($signed(volt_s) < 8'sd3);
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) volt_rd <= 8'h00;
        else volt_rd <= volt_small ? 8'h00 : volt_s;
    end

    // Sticky events; a new event beats the read that clears it
    wire logic [mtrb_pkg::NEV-1:0] events = {ring_hit, tone_done, abort_now, cr_done};
    wire logic [mtrb_pkg::NEV-1:0] next_status = (rd_stat ? '0 : status) | events;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            status <= '0;
            IRQ    <= 1'b0;
        end else begin
            status <= next_status;
            IRQ    <= |(next_status & mask_val[mtrb_pkg::NEV-1:0]);
        end
    end

    // Flop outputs driven from internal state
    assign CARRIER_OK  = carrier_ok;
    assign ANSWER_TONE = tone;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence carrier_run;
        carrier_s && !carrier_ok;
    endsequence
    sequence e6_data_write;
        w_high && win_mode == mtrb_pkg::WIN_DATA;
    endsequence

    carrier_qual_a: assert property (carrier_run ##1 carrier_ok |->
        $past(cr_cnt) > {1'b0, $past(cret_val)}) else $error("carrier accepted too early");
    carrier_drop_a: assert property (!carrier_s |=> !carrier_ok)
        else $error("carrier kept after loss");
    abort_time_a: assert property (CALL_ABORT |-> !$past(carrier_ok) &&
        $past(cw_cnt) > {1'b0, $past(cwait_val)}) else $error("abort without timeout");
    tone_delay_a: assert property ($rose(tone) |->
        $past(at_cnt) > {1'b0, $past(tdel_val)} && $past(tone_arm)) else $error("tone too early");
    ring_count_a: assert property (RING_VALID |-> $past(ring_rise) &&
        ({1'b0, $past(pulse_cnt)} + 9'h001 >= {1'b0, $past(pulse_min)}))
        else $error("ring burst short");
    volt_pass_a: assert property (!volt_small |=> volt_rd == $past(volt_s))
        else $error("line voltage not passed");
    volt_squelch_a: assert property (volt_small |=> volt_rd == 8'h00)
        else $error("small voltage not zero");
    win_select_a: assert property (wr_dp && dp.idx == mtrb_pkg::IDX_WINDOW_SELECT |=>
        win_mode == $past(wdat)) else $error("window select not stored");
    addr_low_a: assert property (w_low && win_mode == mtrb_pkg::WIN_ADDR |=>
        DSP_ADDR[7:0] == $past(wdat) && $stable(DSP_DATA)) else $error("address low not loaded");
    data_high_a: assert property (e6_data_write |=> DSP_DATA_WR &&
        DSP_DATA[13:8] == $past(wdat[5:0]) ##1
        (!DSP_DATA_WR || $past(w_high && win_mode == mtrb_pkg::WIN_DATA)))
        else $error("data high not loaded");
    ctrl_b_a: assert property (w_high && win_mode == mtrb_pkg::WIN_STATUS |=>
        DSP_CTRL_B == $past(wdat) && $stable(DSP_ADDR)) else $error("control b not loaded");

endmodule
`default_nettype wire

/* File: rtl/mtrb_pkg.sv */
// Notes on behaviour
// - After carrier loss, carrier is accepted again only once it has stayed present at least carrier_return_time x 5/3 ms; reset 0x20.
// - A call is aborted when no carrier is qualified within carrier_wait_timeout seconds; reset 0x3C.
// - In answer mode, answer tone starts answer_tone_delay x 53.33 ms after going off-hook; reset 0x29.
// - A ring burst is valid only once it holds at least ring_pulse_count consecutive pulses; reset 0x03.
// - line_voltage_status returns tip-ring voltage as signed 8-bit two's complement, 1 V per step, MSB is polarity.
// - line_voltage_status reads all zeros whenever the voltage magnitude is below 3 V.
// - dsp_window_select at 0xE8, reset zero, chooses the meaning of window offsets 0xE5 and 0xE6.
// - With select 0x00, writes to 0xE5/0xE6 load DSP address bits 7:0 and 15:8, write only.
// - With select 0x01, writes to 0xE5/0xE6 load DSP data bits 7:0 and 13:8, a 14-bit write-only word.
// - With select 0x02, reads of 0xE5 give DSP status, writes to 0xE5/0xE6 load two control values.
package mtrb_pkg;

    // Timebase units in their own measure
    localparam int CLK_HZ          = 125_000_000;
    localparam int FAST_UNIT_US_N  = 5000;   // 5/3 ms as 5000/3 us
    localparam int FAST_UNIT_DEN   = 3;
    localparam int MID_UNIT_10US   = 5333;   // 53.33 ms
    localparam int SEC_UNIT_S      = 1;
    localparam int FAST_CYCLES     = FAST_UNIT_US_N * (CLK_HZ / 1_000_000) / FAST_UNIT_DEN;
    localparam int MID_CYCLES      = MID_UNIT_10US * (CLK_HZ / 100_000);
    localparam int SEC_CYCLES      = SEC_UNIT_S * CLK_HZ;
    localparam logic [7:0] RING_GAP_UNITS = 8'h04;  // Silence in 53.33 ms units that ends a burst

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CARRIER_RETURN = 8'h37;
    localparam logic [7:0] IDX_CARRIER_WAIT   = 8'h39;
    localparam logic [7:0] IDX_ANSWER_DELAY   = 8'h3a;
    localparam logic [7:0] IDX_RING_COUNT     = 8'h3b;
    localparam logic [7:0] IDX_CALLER_GAIN    = 8'h3c;
    localparam logic [7:0] IDX_RING_CONFIG    = 8'h62;
    localparam logic [7:0] IDX_INTRUSION      = 8'h82;
    localparam logic [7:0] IDX_LINE_VOLTAGE   = 8'hdb;
    localparam logic [7:0] IDX_DIGITAL_GAIN   = 8'hdf;
    localparam logic [7:0] IDX_CORE_CFG_ONE   = 8'he0;
    localparam logic [7:0] IDX_PIN_FUNC_ONE   = 8'he1;
    localparam logic [7:0] IDX_PIN_FUNC_TWO   = 8'he2;
    localparam logic [7:0] IDX_PIN_DIRECTION  = 8'he3;
    localparam logic [7:0] IDX_CORE_CFG_FIVE  = 8'he4;
    localparam logic [7:0] IDX_WINDOW_LOW     = 8'he5;
    localparam logic [7:0] IDX_WINDOW_HIGH    = 8'he6;
    localparam logic [7:0] IDX_WINDOW_SELECT  = 8'he8;
    localparam logic [7:0] IDX_IRQ_STATUS     = 8'hfc;
    localparam logic [7:0] IDX_IRQ_MASK       = 8'hfd;

    // Storage slots of the read/write registers
    localparam int         NSLOT     = 15;
    localparam logic [3:0] SLOT_CRET  = 4'h0;
    localparam logic [3:0] SLOT_CWAIT = 4'h1;
    localparam logic [3:0] SLOT_TDEL  = 4'h2;
    localparam logic [3:0] SLOT_RPC  = 4'h3;
    localparam logic [3:0] SLOT_WIN  = 4'hd;
    localparam logic [3:0] SLOT_MASK = 4'he;
    localparam logic [3:0] SLOT_NONE = 4'hf;

    // Window modes
    localparam logic [7:0] WIN_ADDR   = 8'h00;
    localparam logic [7:0] WIN_DATA   = 8'h01;
    localparam logic [7:0] WIN_STATUS = 8'h02;

    // Interrupt status bits
    localparam int EV_CARRIER = 0;
    localparam int EV_ABORT   = 1;
    localparam int EV_TONE    = 2;
    localparam int EV_RING    = 3;
    localparam int NEV        = 4;

    // Bus address phase held over into the data phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] idx;
    } mtrb_aphase_t;

    // One-cycle timebase enables
    typedef struct packed {
        logic fast;
        logic mid;
        logic sec;
    } mtrb_ticks_t;

    // Index to storage slot
    function automatic logic [3:0] reg_slot(input logic [7:0] idx);
        if (idx == IDX_CARRIER_RETURN) reg_slot = 4'h0;
        else if (idx == IDX_CARRIER_WAIT) reg_slot = 4'h1;
        else if (idx == IDX_ANSWER_DELAY) reg_slot = 4'h2;
        else if (idx == IDX_RING_COUNT) reg_slot = 4'h3;
        else if (idx == IDX_CALLER_GAIN) reg_slot = 4'h4;
        else if (idx == IDX_RING_CONFIG) reg_slot = 4'h5;
        else if (idx == IDX_INTRUSION) reg_slot = 4'h6;
        else if (idx == IDX_DIGITAL_GAIN) reg_slot = 4'h7;
        else if (idx == IDX_CORE_CFG_ONE) reg_slot = 4'h8;
        else if (idx == IDX_PIN_FUNC_ONE) reg_slot = 4'h9;
        else if (idx == IDX_PIN_FUNC_TWO) reg_slot = 4'ha;
        else if (idx == IDX_PIN_DIRECTION) reg_slot = 4'hb;
        else if (idx == IDX_CORE_CFG_FIVE) reg_slot = 4'hc;
        else if (idx == IDX_WINDOW_SELECT) reg_slot = 4'hd;
        else if (idx == IDX_IRQ_MASK) reg_slot = 4'he;
        else reg_slot = SLOT_NONE;
    endfunction

    // Reset value of each slot
    function automatic logic [7:0] slot_reset(input logic [3:0] slot);
        case (slot)
            4'h0: slot_reset = 8'h20;
            4'h1: slot_reset = 8'h3c;
            4'h2: slot_reset = 8'h29;
            4'h3: slot_reset = 8'h03;
            4'h4: slot_reset = 8'h01;
            4'h5: slot_reset = 8'h41;
            4'h6: slot_reset = 8'h08;
            4'h7: slot_reset = 8'h0c;
            4'h8: slot_reset = 8'h22;
            4'h9: slot_reset = 8'h04;
            default: slot_reset = 8'h00;
        endcase
    endfunction

    // Unit counter has run past the programmed count
    function automatic logic expired(input logic [8:0] cnt, input logic [7:0] val);
        expired = cnt > {1'b0, val};
    endfunction

    // Saturating count
    function automatic logic [8:0] inc9(input logic [8:0] cnt);
        inc9 = (cnt == 9'h1ff) ? cnt : cnt + 9'h001;
    endfunction

endpackage

/* File: tb/mtrb_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module mtrb_top_tb;
    localparam int FAST = 10;
    localparam int MID  = 30;
    localparam int SEC  = 60;
    logic        CORE_CLK = 1'b0, RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
    logic [1:0]  HTRANS = 2'h0;
    logic [2:0]  HSIZE = 3'h2;
    logic        CARRIER_DET = 1'b0, RING_PULSE = 1'b0, OFF_HOOK = 1'b0;
    logic        ANSWER_MODE = 1'b0, CALL_START = 1'b0;
    logic [7:0]  LINE_VOLTAGE = 8'h00, DSP_STATUS = 8'h00, DSP_CTRL_A, DSP_CTRL_B;
    wire  logic [31:0] HRDATA;
    wire  logic        HREADYOUT, HRESP, CARRIER_OK, CALL_ABORT, ANSWER_TONE, RING_VALID;
    wire  logic [15:0] DSP_ADDR;
    wire  logic [13:0] DSP_DATA;
    wire  logic        DSP_DATA_WR, IRQ;
    int          fail_count = 0, checks_done = 0, ring_seen = 0, wr_seen = 0;
    int          mdl [256];
    logic [7:0]  ids [21] = '{8'h37, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h62, 8'h82, 8'hdf, 8'he0,
                              8'he1, 8'he2, 8'he3, 8'he4, 8'hfd, 8'he8, 8'hfc, 8'he5, 8'he6,
                              8'hdb, 8'h00, 8'h38};
    logic [7:0]  volts [6] = '{8'hfd, 8'hfe, 8'h02, 8'h03, 8'h80, 8'h7f};
    logic [31:0] rd;
    logic [7:0]  a, b, c, d;

    mtrb_top #(.FAST_CYCLES(FAST), .MID_CYCLES(MID), .SEC_CYCLES(SEC)) dut (
        .CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CARRIER_DET(CARRIER_DET),
        .RING_PULSE(RING_PULSE), .OFF_HOOK(OFF_HOOK), .ANSWER_MODE(ANSWER_MODE),
        .CALL_START(CALL_START), .LINE_VOLTAGE(LINE_VOLTAGE), .DSP_STATUS(DSP_STATUS),
        .CARRIER_OK(CARRIER_OK), .CALL_ABORT(CALL_ABORT), .ANSWER_TONE(ANSWER_TONE),
        .RING_VALID(RING_VALID), .DSP_ADDR(DSP_ADDR), .DSP_DATA(DSP_DATA),
        .DSP_DATA_WR(DSP_DATA_WR), .DSP_CTRL_A(DSP_CTRL_A), .DSP_CTRL_B(DSP_CTRL_B), .IRQ(IRQ));

    // Free-running clock and pulse counters for one-cycle outputs
    initial begin
        forever #4 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) begin
        if (RING_VALID === 1'b1) ring_seen++;
        if (DSP_DATA_WR === 1'b1) wr_seen++;
    end

    // Comparisons of values and of measured delays
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    // One AHB-Lite single transfer; waits on ready in both phases
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge CORE_CLK);
        HSEL <= 1'b1; HADDR <= {22'h0, idx, 2'b00}; HTRANS <= 2'h2; HWRITE <= w;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= {24'h0, wd};
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        chk("hresp", 32'h0, {31'h0, HRESP});
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] idx, input int exp);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("reg_%h", idx), exp, rd);
    endtask

    // Reset and the matching model state; every slot not listed is zero
    task automatic do_reset();
        RST <= 1'b1;
        repeat (5) @(posedge CORE_CLK);
        RST <= 1'b0;
        @(posedge CORE_CLK);
        mdl = '{default: 0};
        mdl[8'h37] = 32'h20; mdl[8'h39] = 32'h3c; mdl[8'h3a] = 32'h29; mdl[8'h3b] = 32'h03;
        mdl[8'h3c] = 32'h01; mdl[8'h62] = 32'h41; mdl[8'h82] = 32'h08; mdl[8'hdf] = 32'h0c;
        mdl[8'he0] = 32'h22; mdl[8'he1] = 32'h04;
    endtask
    task automatic all_regs();
        for (int i = 0; i < 21; i++) rd_chk(ids[i], mdl[ids[i]]);
    endtask

    // Cycles from now until a level or pulse output is seen high
    function automatic logic out_sel(input int k);
        return (k == 0) ? CARRIER_OK : (k == 1) ? CALL_ABORT : ANSWER_TONE;
    endfunction
    task automatic timed(input string nm, input int k, input int lo, input int hi);
        int n;
        n = 0;
        while (out_sel(k) !== 1'b1 && n < hi + 50) begin
            @(posedge CORE_CLK); #1; n++;
        end
        chk_rng(nm, lo, hi, n);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Hang guard, far beyond the several hundred cycles the run needs
    initial begin
        #400000;
        fail_count++;
        results();
    end

    initial begin
        void'($urandom(32'hbfe8b81b));
        do_reset();
        all_regs();
        // Call abort with no carrier; status bit 1 drives the interrupt once unmasked
        bus(1'b1, 8'h39, 8'h01);
        @(posedge CORE_CLK); CALL_START <= 1'b1;
        timed("call_abort", 1, SEC, 2 * SEC + 6);
        CALL_START <= 1'b0;
        chk("irq_masked", 32'h0, {31'h0, IRQ});
        bus(1'b1, 8'hfd, 8'h02);
        @(posedge CORE_CLK); #1;
        chk("irq_on", 32'h1, {31'h0, IRQ});
        rd_chk(8'hfc, 32'h02);
        chk("irq_clear", 32'h0, {31'h0, IRQ});
        // Carrier qualification over two fast units, then loss
        bus(1'b1, 8'h37, 8'h02);
        @(posedge CORE_CLK); CARRIER_DET <= 1'b1;
        timed("carrier_ok", 0, 2 * FAST, 3 * FAST + 6);
        CARRIER_DET <= 1'b0;
        repeat (5) @(posedge CORE_CLK); #1;
        chk("carrier_drop", 32'h0, {31'h0, CARRIER_OK});
        // Answer tone after two mid units off-hook in answer mode
        bus(1'b1, 8'h3a, 8'h02);
        @(posedge CORE_CLK); OFF_HOOK <= 1'b1; ANSWER_MODE <= 1'b1;
        timed("answer_tone", 2, 2 * MID, 3 * MID + 6);
        OFF_HOOK <= 1'b0;
        repeat (5) @(posedge CORE_CLK); #1;
        chk("tone_drop", 32'h0, {31'h0, ANSWER_TONE});
        // Four close pulses with a count of three: one valid burst, on the third
        for (int i = 1; i <= 4; i++) begin
            @(posedge CORE_CLK); RING_PULSE <= 1'b1;
            repeat (4) @(posedge CORE_CLK); RING_PULSE <= 1'b0;
            repeat (4) @(posedge CORE_CLK);
            if (i == 2) chk("ring_early", 32'h0, ring_seen);
        end
        chk("ring_once", 32'h1, ring_seen);
        rd_chk(8'hfc, 32'h0d);
        // Line voltage: boundaries of the dead zone, then random readings
        for (int i = 0; i < 12; i++) begin
            a = (i < 6) ? volts[i] : 8'($urandom);
            @(posedge CORE_CLK); LINE_VOLTAGE <= a;
            repeat (4) @(posedge CORE_CLK);
            rd_chk(8'hdb, ($signed(a) > -3 && $signed(a) < 3) ? 0 : a);
        end
        // Window modes: address, data, then status and control
        {a, b, c, d} = $urandom;
        bus(1'b1, 8'he5, a); bus(1'b1, 8'he6, b);
        chk("dsp_addr", {b, a}, DSP_ADDR);
        rd_chk(8'he5, 0);
        bus(1'b1, 8'he8, 8'h01); bus(1'b1, 8'he5, c); bus(1'b1, 8'he6, d);
        @(posedge CORE_CLK); #1;
        chk("dsp_data", {d[5:0], c}, DSP_DATA);
        chk("dsp_wr", 32'h1, wr_seen);
        chk("addr_kept", {b, a}, DSP_ADDR);
        bus(1'b1, 8'he8, 8'h02);
        @(posedge CORE_CLK); DSP_STATUS <= d;
        repeat (4) @(posedge CORE_CLK);
        rd_chk(8'he5, d);
        bus(1'b1, 8'he5, c ^ 8'h5a); bus(1'b1, 8'he6, a ^ 8'ha5);
        chk("ctrl_a", c ^ 8'h5a, DSP_CTRL_A);
        chk("ctrl_b", a ^ 8'ha5, DSP_CTRL_B);
        chk("data_kept", {d[5:0], c}, DSP_DATA);
        rd_chk(8'he8, 32'h02);
        // Random writes, read-only and unmapped places ignore them; second reset
        do_reset();
        LINE_VOLTAGE <= 8'h00;
        for (int i = 0; i < 21; i++) begin
            if (i > 13 && i < 18) continue;
            a = 8'($urandom);
            bus(1'b1, ids[i], a);
            if (i < 14) mdl[ids[i]] = a;
        end
        all_regs();
        do_reset();
        all_regs();
        results();
    end
endmodule
`default_nettype wire
